//--- hw/sau_core.sv
`timescale 1ns/100ps
module sau_core
  import sau_pkg::*;
#(
  parameter int N_CH = 63,
  // revision value is arbitrary
  parameter logic [11:0] REV_ID = 12'h100
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire sau_pb_req_t pb_req_i,
  output logic [31:0] pb_rdata_o,
  input wire sau_hs_req_t hs_req_i,
  output sau_rsp_t hs_rsp_o,
  output sau_mst_req_t mst_req_o,
  input wire sau_rsp_t mst_rsp_i,
  output logic irq_o
);

  // ==========================================================
  // state
  sau_state_t state_q;
  logic en_q, setup_q, berr_q, open_q, idle_q, irq_q;
  logic [7:0] ul_len_q, key_q, flags_q, irq_en_q, ul_cnt_q, set_v, clr_v;
  logic [31:0] cel_q, ceh_q, pb_rdata_q;
  logic [5:0] ul_ch_q;
  logic ul_act_q;
  logic [31:0] rt_q [N_CH];
  sau_rsp_t rsp_q;
  sau_mst_req_t mst_q;

  // ==========================================================
  // decode
  logic take, is_ul, ul_rd, ul_wr, err_any, key_bad, ul_go;
  logic ch_acc, rt_acc, ch_ok, in_range, consume, expire, pb_we;
  logic [5:0] ch_idx;
  logic [63:0] cer;
  logic [31:0] rt_sel;

  assign pb_we = pb_req_i.sel && pb_req_i.wr;
  assign take = (state_q == SAU_ST_IDLE_S) && hs_req_i.valid;
  assign is_ul = hs_req_i.addr == SAU_UNLOCK_OFF;
  assign ch_idx = hs_req_i.addr[7:2];
  assign ul_rd = take && is_ul && !hs_req_i.wr;
  assign ul_wr = take && is_ul && hs_req_i.wr;
  assign err_any = |(flags_q & SAU_ERR_MASK);
  assign key_bad = hs_req_i.wdata[15:8] != key_q;
  assign ul_go = ul_wr && !err_any && !key_bad;
  assign rt_acc = take && !is_ul && setup_q;
  assign ch_acc = take && !is_ul && !setup_q;
  assign cer = {1'b0, ceh_q[30:0], cel_q};
  assign in_range = 32'(ch_idx) < N_CH;
  assign rt_sel = in_range ? rt_q[ch_idx] : 32'h0000_0000;
  assign ch_ok = en_q && in_range && cer[ch_idx] &&
                 (open_q || (ul_act_q && ul_ch_q == ch_idx));
  assign consume = ch_acc && ch_ok;
  assign expire = ul_act_q && !consume && !ul_go && ul_cnt_q <= 8'h01;

  always_comb begin
    set_v = 8'h00;
    set_v[SAU_F_TMO] = expire;
    set_v[SAU_F_CAS] = consume && !open_q;
    set_v[SAU_F_DENY] = ch_acc && !ch_ok;
    set_v[SAU_F_ULRD] = ul_rd;
    set_v[SAU_F_KEY] = ul_wr && !err_any && key_bad;
    set_v[SAU_F_BLOCK] = ul_wr && err_any;
    set_v[SAU_F_MST] = (state_q == SAU_ST_MST_S) && mst_rsp_i.done
                       && mst_rsp_i.err;
    set_v[SAU_F_RTADR] = rt_acc && hs_req_i.wr
                         && hs_req_i.wdata[31:16] < SAU_RT_LOW_LIMIT;
  end

  assign clr_v = (pb_we && pb_req_i.addr == SAU_FCLR_OFF) ?
                 pb_req_i.wdata[7:0] : 8'h00;

  // ==========================================================
  // channel-side sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= SAU_ST_IDLE_S;
      rsp_q <= '0;
      mst_q <= '0;
    end else begin
      unique case (state_q)
        SAU_ST_IDLE_S: begin
          rsp_q <= '0;
          if (take) begin
            state_q <= SAU_ST_WAIT_S;
            rsp_q.done <= 1'b1;
            if (ul_rd || (ch_acc && !ch_ok))
              rsp_q.err <= berr_q;
            if (rt_acc && !hs_req_i.wr)
              rsp_q.rdata <= rt_sel;
            if (consume) begin
              // forward to remap target
              state_q <= SAU_ST_MST_S;
              rsp_q.done <= 1'b0;
              mst_q.valid <= 1'b1;
              mst_q.wr <= hs_req_i.wr;
              mst_q.addr <= rt_sel;
              mst_q.wdata <= hs_req_i.wdata;
            end
          end
        end
        SAU_ST_MST_S: begin
          if (mst_rsp_i.done) begin
            mst_q.valid <= 1'b0;
            state_q <= SAU_ST_WAIT_S;
            rsp_q.done <= 1'b1;
            rsp_q.err <= mst_rsp_i.err && berr_q;
            rsp_q.rdata <= mst_rsp_i.rdata;
          end
        end
        SAU_ST_WAIT_S: begin
          // one dead cycle so a held request is not taken twice
          rsp_q <= '0;
          state_q <= SAU_ST_IDLE_S;
        end
        default: begin
          state_q <= SAU_ST_IDLE_S;
          rsp_q <= '0;
          mst_q <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      setup_q <= 1'b0;
      berr_q <= 1'b0;
    end else if (pb_we && pb_req_i.addr == SAU_CMD_OFF) begin
      if (pb_req_i.wdata[SAU_CMD_STOP])
        en_q <= 1'b0;
      else if (pb_req_i.wdata[SAU_CMD_EN])
        en_q <= 1'b1;
      if (pb_req_i.wdata[SAU_CMD_SETUP_OUT])
        setup_q <= 1'b0;
      else if (pb_req_i.wdata[SAU_CMD_SETUP_IN])
        setup_q <= 1'b1;
      if (pb_req_i.wdata[SAU_CMD_BOFF])
        berr_q <= 1'b0;
      else if (pb_req_i.wdata[SAU_CMD_BON])
        berr_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      open_q <= 1'b0;
      ul_len_q <= 8'h00;
      key_q <= 8'h00;
      cel_q <= 32'h0000_0000;
      ceh_q <= 32'h0000_0000;
      irq_en_q <= 8'h00;
    end else if (pb_we) begin
      unique case (pb_req_i.addr)
        SAU_SETUP_OFF: begin
          open_q <= pb_req_i.wdata[SAU_OPEN_BIT];
          ul_len_q <= pb_req_i.wdata[15:8];
          key_q <= pb_req_i.wdata[7:0];
        end
        SAU_CEH_OFF: ceh_q <= {1'b0, pb_req_i.wdata[30:0]};
        SAU_CEL_OFF: cel_q <= pb_req_i.wdata;
        SAU_IES_OFF: irq_en_q <= irq_en_q | pb_req_i.wdata[7:0];
        SAU_IEC_OFF: irq_en_q <= irq_en_q & ~pb_req_i.wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      flags_q <= SAU_STAT_RST[7:0];
    else
      flags_q <= (flags_q & ~clr_v) | set_v;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      idle_q <= SAU_STAT_RST[SAU_ST_IDLE];
    else if (consume)
      idle_q <= 1'b0;
    else if (state_q == SAU_ST_MST_S && mst_rsp_i.done)
      idle_q <= 1'b1;
  end

  // ==========================================================
  // unlock window
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ul_act_q <= 1'b0;
      ul_ch_q <= 6'h00;
      ul_cnt_q <= 8'h00;
    end else if (ul_go) begin
      // a new unlock replaces any other
      ul_act_q <= 1'b1;
      ul_ch_q <= hs_req_i.wdata[5:0];
      ul_cnt_q <= ul_len_q;
    end else if (consume || expire) begin
      ul_act_q <= 1'b0;
    end else if (ul_act_q) begin
      ul_cnt_q <= ul_cnt_q - 8'h01;
    end
  end

  // ==========================================================
  // remap targets
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_rt
      always_ff @(posedge core_clk_i) begin
        if (rst_i)
          rt_q[g] <= 32'h0000_0000;
        else if (rt_acc && hs_req_i.wr && ch_idx == 6'(g))
          rt_q[g] <= hs_req_i.wdata;
      end
    end
  endgenerate

  // ==========================================================
  // peripheral read port and interrupt
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pb_rdata_q <= 32'h0000_0000;
    end else if (pb_req_i.sel && !pb_req_i.wr) begin
      unique case (pb_req_i.addr)
        SAU_CEH_OFF: pb_rdata_q <= ceh_q;
        SAU_CEL_OFF: pb_rdata_q <= cel_q;
        SAU_STAT_OFF: pb_rdata_q <= {21'h000000, idle_q, setup_q, en_q, flags_q};
        SAU_MASK_OFF: pb_rdata_q <= {24'h000000, irq_en_q};
        SAU_PARAM_OFF: pb_rdata_q <= {26'h0000000, 6'(N_CH)};
        SAU_REV_OFF: pb_rdata_q <= {20'h00000, REV_ID};
        default: pb_rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags_q & irq_en_q);
  end

  assign pb_rdata_o = pb_rdata_q;
  assign hs_rsp_o = rsp_q;
  assign mst_req_o = mst_q;
  assign irq_o = irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_cmd_en;
    pb_we && pb_req_i.addr == SAU_CMD_OFF && pb_req_i.wdata[1:0] == 2'b01 |=> en_q;
  endproperty
  a_cmd_en: assert property (p_cmd_en) else $error("enable command ignored");

  property p_setup;
    pb_we && pb_req_i.addr == SAU_CMD_OFF && pb_req_i.wdata[3:2] == 2'b10
      |=> !setup_q;
  endproperty
  a_setup: assert property (p_setup) else $error("setup exit ignored");

  property p_sticky;
    !(pb_we && pb_req_i.addr == SAU_FCLR_OFF) |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_idle;
    consume |=> !idle_q && mst_q.valid && mst_q.addr == $past(rt_sel);
  endproperty
  a_idle: assert property (p_idle) else $error("forward did not start");

  property p_deny;
    ch_acc && !ch_ok |=> flags_q[SAU_F_DENY] && rsp_q.done && !mst_q.valid;
  endproperty
  a_deny: assert property (p_deny) else $error("denied access forwarded");

  property p_key;
    ul_wr && !err_any && key_bad
      |=> flags_q[SAU_F_KEY] && !$rose(ul_act_q) && $stable(ul_ch_q) ##1 !rsp_q.done;
  endproperty
  a_key: assert property (p_key) else $error("bad key not flagged");

  property p_unlock_blocked_fault;
    ul_wr && err_any && !ul_act_q |=> flags_q[SAU_F_BLOCK] && !ul_act_q;
  endproperty
  a_unlock_blocked_fault: assert property (p_unlock_blocked_fault) else $error("unlock not aborted");

  property p_unlock_port_read_fault;
    ul_rd |=> flags_q[SAU_F_ULRD];
  endproperty
  a_unlock_port_read_fault: assert property (p_unlock_port_read_fault) else $error("unlock read not flagged");

  property p_expire;
    ul_go && ul_len_q == 8'h03 ##1 (!consume && !ul_go)[*3]
      |=> !ul_act_q && flags_q[SAU_F_TMO];
  endproperty
  a_expire: assert property (p_expire) else $error("unlock window wrong");

  property p_irq;
    |(flags_q & irq_en_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_rtadr;
    rt_acc && hs_req_i.wr && hs_req_i.wdata[31:16] < SAU_RT_LOW_LIMIT
      |=> flags_q[SAU_F_RTADR];
  endproperty
  a_rtadr: assert property (p_rtadr) else $error("bad target not flagged");

  property p_mst_err;
    state_q == SAU_ST_MST_S && mst_rsp_i.done && mst_rsp_i.err
      |=> flags_q[SAU_F_MST] && hs_rsp_o.done && hs_rsp_o.err == $past(berr_q);
  endproperty
  a_mst_err: assert property (p_mst_err) else $error("master error not reported");

  property p_cas;
    consume && !open_q |=> flags_q[SAU_F_CAS] && !ul_act_q;
  endproperty
  a_cas: assert property (p_cas) else $error("unlocked access not counted");

  property p_one_win;
    ul_go |=> ul_act_q && ul_ch_q == $past(hs_req_i.wdata[5:0])
      && ul_cnt_q == $past(ul_len_q);
  endproperty
  a_one_win: assert property (p_one_win) else $error("unlock not taken over");

  property p_mst_hold;
    mst_q.valid && !mst_rsp_i.done
      |=> mst_q.valid && $stable(mst_q.addr) && $stable(mst_q.wdata);
  endproperty
  a_mst_hold: assert property (p_mst_hold) else $error("forward dropped early");

endmodule // sau_core

//--- hw/sau_pkg.sv
// Operation
// - config registers 0x00-0x28, slots 4*n, unlock 0xFC
// - command bits 0/1 enable/disable, status bit 8
// - command bits 2/3 setup entry/exit, status bit 9
// - command bits 4/5 bus-error response on/off
// - lock setup bit 16 selects open mode
// - unlock lasts count cycles or one access
// - unlock key must match stored key
// - low/high enable masks map channels 0-62
// - idle flag clears on start, sets on completion
// - flags 7:0 cleared only by flag clear
// - remap target upper half below 0xFFFC flagged
// - master bus error sets status bit 6
// - unlock with error pending aborts, sets bit 5
// - wrong unlock key sets status bit 4
// - reading unlock port sets status bit 3
// - locked or disabled channel access denied, bit 2
// - one access after unlock sets bit 1
// - unlock expiry without access sets bit 0
// - interrupt while masked flag set
// - only one channel unlocked at a time
package sau_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] SAU_CMD_OFF = 8'h00;
  localparam logic [7:0] SAU_SETUP_OFF = 8'h04;
  localparam logic [7:0] SAU_CEH_OFF = 8'h08;
  localparam logic [7:0] SAU_CEL_OFF = 8'h0C;
  localparam logic [7:0] SAU_STAT_OFF = 8'h10;
  localparam logic [7:0] SAU_IES_OFF = 8'h14;
  localparam logic [7:0] SAU_IEC_OFF = 8'h18;
  localparam logic [7:0] SAU_MASK_OFF = 8'h1C;
  localparam logic [7:0] SAU_FCLR_OFF = 8'h20;
  localparam logic [7:0] SAU_PARAM_OFF = 8'h24;
  localparam logic [7:0] SAU_REV_OFF = 8'h28;
  localparam logic [7:0] SAU_UNLOCK_OFF = 8'hFC;

  // ==========================================================
  // field positions and values
  localparam int SAU_CMD_EN = 0;
  localparam int SAU_CMD_STOP = 1;
  localparam int SAU_CMD_SETUP_IN = 2;
  localparam int SAU_CMD_SETUP_OUT = 3;
  localparam int SAU_CMD_BON = 4;
  localparam int SAU_CMD_BOFF = 5;
  localparam int SAU_OPEN_BIT = 16;
  localparam int SAU_ST_EN = 8;
  localparam int SAU_ST_SETUP = 9;
  localparam int SAU_ST_IDLE = 10;
  localparam int SAU_F_TMO = 0;
  localparam int SAU_F_CAS = 1;
  localparam int SAU_F_DENY = 2;
  localparam int SAU_F_ULRD = 3;
  localparam int SAU_F_KEY = 4;
  localparam int SAU_F_BLOCK = 5;
  localparam int SAU_F_MST = 6;
  localparam int SAU_F_RTADR = 7;
  localparam logic [7:0] SAU_ERR_MASK = 8'hFD;
  localparam logic [15:0] SAU_RT_LOW_LIMIT = 16'hFFFC;
  localparam logic [31:0] SAU_STAT_RST = 32'h0000_0400;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sau_pb_req_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sau_hs_req_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sau_mst_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } sau_rsp_t;

  typedef enum logic [1:0] {
    SAU_ST_IDLE_S = 2'b00,
    SAU_ST_MST_S = 2'b01,
    SAU_ST_WAIT_S = 2'b10
  } sau_state_t;

endpackage

//--- tb/sau_target_model.sv
`timescale 1ns/100ps
module sau_target_model
  import sau_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire sau_mst_req_t req_i,
  input wire logic [3:0] delay_i,
  input wire logic err_i,
  output sau_rsp_t rsp_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o
);
  logic [3:0] cnt_q;

  // ==========================================================
  // remap target: answers after delay_i wait cycles
  always_ff @(posedge core_clk_i) begin
    rsp_o.done <= 1'b0;
    rsp_o.err <= 1'b0;
    // read data is not held outside the answer cycle
    rsp_o.rdata <= ~rsp_o.rdata;
    if (rst_i) begin
      cnt_q <= 4'h0;
      rsp_o.rdata <= 32'h0;
      wr_addr_o <= 32'h0;
      wr_data_o <= 32'h0;
    end else if (req_i.valid && !rsp_o.done) begin
      if (cnt_q >= delay_i) begin
        cnt_q <= 4'h0;
        rsp_o.done <= 1'b1;
        rsp_o.err <= err_i;
        rsp_o.rdata <= ~req_i.addr;
        if (req_i.wr) begin
          wr_addr_o <= req_i.addr;
          wr_data_o <= req_i.wdata;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // sau_target_model

//--- tb/secure_access_remap_unit_tb.sv
`timescale 1ns/100ps
module secure_access_remap_unit_tb
  import sau_pkg::*;
;
  logic core_clk_i;
  logic rst_i;
  sau_pb_req_t pb_req;
  sau_hs_req_t hs_req;
  sau_mst_req_t mst_req;
  sau_rsp_t hs_rsp;
  sau_rsp_t mst_rsp;
  logic [31:0] pb_rdata;
  logic [31:0] wr_a;
  logic [31:0] wr_d;
  logic irq;
  logic [3:0] dly;
  logic merr;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic [7:0] RA [8] = '{8'h10, 8'h1C, 8'h08, 8'h0C, 8'h24, 8'h28, 8'h00, 8'h2C};
  localparam logic [31:0] RV [8] = '{SAU_STAT_RST, 32'h0, 32'h0, 32'h0, 32'h3F, 32'h100,
                                     32'h0, 32'h0};

  sau_core u_dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pb_req_i(pb_req),
    .pb_rdata_o(pb_rdata),
    .hs_req_i(hs_req),
    .hs_rsp_o(hs_rsp),
    .mst_req_o(mst_req),
    .mst_rsp_i(mst_rsp),
    .irq_o(irq)
  );

  sau_target_model u_tgt (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .req_i(mst_req),
    .delay_i(dly),
    .err_i(merr),
    .rsp_o(mst_rsp),
    .wr_addr_o(wr_a),
    .wr_data_o(wr_d)
  );

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // peripheral bus cycle; for reads d is the expected word
  task automatic pb(input logic w, input logic [7:0] a, input logic [31:0] d);
    pb_req = '{1'b1, w, a, d};
    @(negedge core_clk_i);
    pb_req.sel = 1'b0;
    if (!w) chk(pb_rdata, d);
    @(negedge core_clk_i);
  endtask

  // channel window access; rdata checked on good reads only
  task automatic ha(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic e, input logic [31:0] r);
    int i;
    i = 0;
    hs_req = '{1'b1, w, a, d};
    do begin
      @(negedge core_clk_i);
      i++;
    end while (hs_rsp.done !== 1'b1 && i < 100);
    hs_req.valid = 1'b0;
    chk({31'h0, hs_rsp.done}, 32'h1);
    chk({31'h0, hs_rsp.err}, {31'h0, e});
    if (!w && !e) chk(hs_rsp.rdata, r);
    @(negedge core_clk_i);
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    results();
  end

  // ==========================================================
  // tests
  initial begin
    rst_i = 1'b1;
    pb_req = '0;
    hs_req = '0;
    dly = 4'h0;
    merr = 1'b0;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    for (int k = 0; k < 8; k++) pb(1'b0, RA[k], RV[k]);
    pb(1'b1, 8'h00, 32'h11);
    pb(1'b1, 8'h10, 32'hFFFFFFFF);
    pb(1'b0, 8'h10, 32'h500);
    pb(1'b1, 8'h00, 32'h4);
    pb(1'b0, 8'h10, 32'h700);
    ha(1'b1, 8'h00, 32'hFFFC0010, 1'b0, 32'h0);
    ha(1'b1, 8'h04, 32'h12340000, 1'b0, 32'h0);
    pb(1'b0, 8'h10, 32'h780);
    ha(1'b0, 8'h00, 32'h0, 1'b0, 32'hFFFC0010);
    ha(1'b1, 8'h84, 32'hFFFD0040, 1'b0, 32'h0);
    pb(1'b1, 8'h20, 32'hFF);
    pb(1'b0, 8'h10, 32'h700);
    pb(1'b1, 8'h00, 32'hC);
    pb(1'b0, 8'h10, 32'h500);
    pb(1'b1, 8'h0C, 32'h1);
    pb(1'b1, 8'h08, 32'h2);
    pb(1'b0, 8'h0C, 32'h1);
    pb(1'b0, 8'h08, 32'h2);
    pb(1'b1, 8'h04, 32'h10000);
    ha(1'b1, 8'h00, 32'hCAFE0001, 1'b0, 32'h0);
    chk(wr_a, 32'hFFFC0010);
    chk(wr_d, 32'hCAFE0001);
    dly = 4'h5;
    fork
      ha(1'b0, 8'h84, 32'h0, 1'b0, 32'h0002FFBF);
      begin
        repeat (3) @(negedge core_clk_i);
        pb(1'b0, 8'h10, 32'h100);
      end
    join
    pb(1'b0, 8'h10, 32'h500);
    ha(1'b0, 8'h04, 32'h0, 1'b1, 32'h0);
    pb(1'b0, 8'h10, 32'h504);
    pb(1'b1, 8'h20, 32'hFF);
    pb(1'b1, 8'h04, 32'h205A);
    ha(1'b1, 8'h00, 32'h1, 1'b1, 32'h0);
    pb(1'b1, 8'h20, 32'hFF);
    ha(1'b1, 8'hFC, 32'h3300, 1'b0, 32'h0);
    pb(1'b0, 8'h10, 32'h510);
    ha(1'b1, 8'hFC, 32'h5A00, 1'b0, 32'h0);
    ha(1'b1, 8'h00, 32'h1, 1'b1, 32'h0);
    pb(1'b0, 8'h10, 32'h534);
    pb(1'b1, 8'h20, 32'hFF);
    ha(1'b1, 8'hFC, 32'h5A00, 1'b0, 32'h0);
    ha(1'b1, 8'h00, 32'h2222, 1'b0, 32'h0);
    pb(1'b0, 8'h10, 32'h502);
    ha(1'b1, 8'h00, 32'h3333, 1'b1, 32'h0);
    chk(wr_d, 32'h2222);
    pb(1'b1, 8'h20, 32'hFF);
    ha(1'b1, 8'hFC, 32'h5A00, 1'b0, 32'h0);
    ha(1'b1, 8'hFC, 32'h5A21, 1'b0, 32'h0);
    ha(1'b0, 8'h00, 32'h0, 1'b1, 32'h0);
    ha(1'b0, 8'h84, 32'h0, 1'b0, 32'h0002FFBF);
    pb(1'b0, 8'h10, 32'h506);
    pb(1'b1, 8'h04, 32'h35A);
    pb(1'b1, 8'h20, 32'hFF);
    ha(1'b1, 8'hFC, 32'h5A00, 1'b0, 32'h0);
    repeat (40) @(negedge core_clk_i);
    pb(1'b0, 8'h10, 32'h501);
    ha(1'b0, 8'h00, 32'h0, 1'b1, 32'h0);
    pb(1'b1, 8'h20, 32'hFF);
    ha(1'b0, 8'hFC, 32'h0, 1'b1, 32'h0);
    pb(1'b0, 8'h10, 32'h508);
    pb(1'b1, 8'h20, 32'hFF);
    pb(1'b1, 8'h04, 32'h10000);
    merr = 1'b1;
    ha(1'b1, 8'h00, 32'h4444, 1'b1, 32'h0);
    merr = 1'b0;
    pb(1'b0, 8'h10, 32'h540);
    pb(1'b1, 8'h20, 32'hFF);
    pb(1'b1, 8'h14, 32'h4);
    pb(1'b0, 8'h1C, 32'h4);
    ha(1'b0, 8'h04, 32'h0, 1'b1, 32'h0);
    chk({31'h0, irq}, 32'h1);
    pb(1'b1, 8'h18, 32'h4);
    pb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pb(1'b1, 8'h20, 32'hFF);
    pb(1'b0, 8'h10, 32'h500);
    pb(1'b1, 8'h00, 32'h3);
    pb(1'b0, 8'h10, 32'h400);
    ha(1'b1, 8'h00, 32'h5555, 1'b1, 32'h0);
    chk(wr_d, 32'h4444);
    pb(1'b0, 8'h10, 32'h404);
    pb(1'b1, 8'h00, 32'h30);
    ha(1'b1, 8'h00, 32'h0, 1'b0, 32'h0);
    results();
  end
endmodule // secure_access_remap_unit_tb
